// ---- verilog/hlprc_pkg.sv ----
// Shared constants of the wireless input-device packet and rate-control block
package hlprc_pkg;
  // Register byte offsets
  localparam logic [7:0] HLPRC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] HLPRC_CFG_OFS    = 8'h04;
  localparam logic [7:0] HLPRC_PWR_OFS    = 8'h08;
  localparam logic [7:0] HLPRC_REPORT_OFS = 8'h0C;
  localparam logic [7:0] HLPRC_STATUS_OFS = 8'h10;
  localparam logic [7:0] HLPRC_TXCMD_OFS  = 8'h14;
  localparam logic [7:0] HLPRC_RXHDR_OFS  = 8'h18;
  localparam logic [7:0] HLPRC_RXBYTE_OFS = 8'h1C;
  localparam logic [7:0] HLPRC_MID_OFS    = 8'h20;
  localparam logic [7:0] HLPRC_SEED_OFS   = 8'h30;

  // Header layout
  localparam int HLPRC_TYPE_MSB  = 7;
  localparam int HLPRC_TYPE_LSB  = 4;
  localparam int HLPRC_BACK_CHANNEL_REQUEST_BIT_BIT  = 3;
  localparam int HLPRC_TOGGLE_BIT = 2;

  // Packet type codes
  localparam logic [3:0] HLPRC_T_PAIR     = 4'h0;
  localparam logic [3:0] HLPRC_T_CONNECT  = 4'h1;
  localparam logic [3:0] HLPRC_T_JOIN     = 4'h2;
  localparam logic [3:0] HLPRC_T_PING     = 4'h3;
  localparam logic [3:0] HLPRC_T_DATA     = 4'h4;
  localparam logic [3:0] HLPRC_T_BACK     = 4'h5;
  localparam logic [3:0] HLPRC_T_NULL     = 4'h7;
  localparam logic [3:0] HLPRC_T_KEY      = 4'h8;
  localparam logic [3:0] HLPRC_T_AUTOBIND = 4'hD;

  // Identifier bytes sit in payload bytes 2 to 5
  localparam logic [2:0] HLPRC_MID_FIRST = 3'h2;
  localparam logic [2:0] HLPRC_MID_LAST  = 3'h5;

  // Reset values of the configuration (plain defaults)
  localparam logic [7:0] HLPRC_WINDOW_RST  = 8'h04;
  localparam logic [7:0] HLPRC_THRMIN_RST  = 8'h02;
  localparam logic [7:0] HLPRC_LEVEL_RST   = 8'h20;
  localparam logic [7:0] HLPRC_PWRLIM_RST  = 8'h03;
  localparam logic [3:0] HLPRC_FLOOR_RST   = 4'h1;
  localparam logic [3:0] HLPRC_CEIL_RST    = 4'h7;
  localparam logic [15:0] HLPRC_SEED_RST   = 16'h0000;

  // Back-channel turnaround delay
  localparam int HLPRC_CLK_MHZ     = 50;
  localparam int HLPRC_BC_DELAY_US = 10;
  localparam int HLPRC_BC_DELAY_CYC = (HLPRC_BC_DELAY_US * HLPRC_CLK_MHZ < 1) ? 1 :
                                      HLPRC_BC_DELAY_US * HLPRC_CLK_MHZ;

  typedef enum logic [1:0] {
    HLPRC_BC_IDLE   = 2'b00,
    HLPRC_BC_WAIT   = 2'b01,
    HLPRC_BC_LISTEN = 2'b11
  } hlprc_bc_t;
endpackage

// ---- verilog/hlprc_mid_mem.sv ----
// Identifier store: one write port, two registered read ports
`timescale 1ns/1ps
module hlprc_mid_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 8
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_a,
  output logic      [WIDTH-1:0]         rdata_a,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_b,
  output logic      [WIDTH-1:0]         rdata_b
);
  logic [WIDTH-1:0] mem_r [DEPTH];

  if (DEPTH < 2) begin : g_chk
    $error("hlprc_mid_mem needs at least two words");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem_r[raddr_a];
      rdata_b <= mem_r[raddr_b];
    end
  end
endmodule

// ---- verilog/hlprc_top.sv ----
// Packet header framer, identifier handling and adaptive data mode / power control
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Failure after the retry limit switches data mode and asks for a resend.
// - A second failure after that switch raises the reconnect request.
// - Retries of successful data packets sum over a window; above threshold switches mode.
// - Every mode switch loads the threshold with the total of the mode left.
// - A zero window total lowers the threshold by one, not below the minimum.
// - Zero total with strong acknowledge lowers power one step, not below floor.
// - Power returns to ceiling on switch, weak acknowledge, or too many retries.
// - In bridge role power stays at the ceiling.
// - In bridge role the data mode follows each received packet.
// - Header upper nibble is the type, lower nibble packet specific.
// - Type codes are fixed constants shared by both ends.
// - Pair and auto-pair requests carry device type in header bits 2:1.
// - Bridge answers pairing with type header echoing device type; identifier follows.
// - Connect request carries device type and stored identifier in bytes 2-5.
// - Bridge answers connect with type 2, bit 3 set when identifier matches.
// - Ping header bit 0 is clear for ping, set for response.
// - Data type 4, back channel 5; bit 3 asks for back-channel data.
// - Toggle bit inverts for each new data packet, kept on resends.
// - Data header bits 1 and 0 carry device type swapped.
// - Bytes after the header are plain byte-aligned payload.
// - Missing acknowledge on a data packet raises the resend request.
// - Acknowledged back-channel request inverts seed upper byte, then waits before listening.
module hlprc_top
  import hlprc_pkg::*;
#(
  parameter int BC_DELAY_CYC = hlprc_pkg::HLPRC_BC_DELAY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             data_mode_r,
  output logic      [3:0]  tx_power_r,
  output logic             reconnect_r,
  output logic      [7:0]  tx_header_r,
  output logic             bc_listen_r,
  output logic      [15:0] crc_seed_r
);
  import hlprc_pkg::*;

  if (BC_DELAY_CYC < 1) begin : g_chk
    $error("BC_DELAY_CYC must be at least one");
  end

  function automatic logic [7:0] sat_dec(input logic [7:0] v, input logic [7:0] lo);
    sat_dec = (v > lo) ? v - 8'h01 : lo;
  endfunction

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[8] ? 8'hFF : s[7:0];
  endfunction

  // Compose a header byte from command fields
  function automatic logic [7:0] build_hdr(input logic [3:0] t, input logic [1:0] dev,
                                           input logic back_channel_request_bit, input logic tog, input logic flag);
    logic [3:0] low;
    low = 4'h0;
    unique case (t)
      HLPRC_T_PAIR, HLPRC_T_AUTOBIND, HLPRC_T_CONNECT: low = {1'b0, dev, 1'b0};
      HLPRC_T_JOIN:                 low = {flag, 3'b000};
      HLPRC_T_PING:                 low = {3'b000, flag};
      HLPRC_T_DATA, HLPRC_T_BACK, HLPRC_T_NULL: low = {back_channel_request_bit, tog, dev[0], dev[1]};
      default:                      low = 4'h0;
    endcase
    build_hdr = {t, low};
  endfunction

  // APB slave: one wait state on every access
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        acc_first;
  logic        wr_en;
  logic        mapped;
  logic        is_mid;
  logic [31:0] rd_mux;
  logic [7:0]  mid_rd;
  logic [7:0]  mid_cmp;

  assign acc_first = psel & penable & ~pready_r;
  assign wr_en     = psel & penable & pready_r & pwrite;
  assign is_mid    = (paddr[7:4] == HLPRC_MID_OFS[7:4]) && (paddr[1:0] == 2'b00);
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign prdata    = prdata_r;

  // Control and configuration
  logic        role_bridge_r;
  logic        link_ready_r;
  logic [7:0]  window_r;
  logic [7:0]  thr_min_r;
  logic [7:0]  level_r;
  logic [7:0]  pwr_lim_r;
  logic [3:0]  floor_r;
  logic [3:0]  ceil_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_bridge_r <= 1'b0;
      link_ready_r  <= 1'b0;
      window_r      <= HLPRC_WINDOW_RST;
      thr_min_r     <= HLPRC_THRMIN_RST;
      level_r       <= HLPRC_LEVEL_RST;
      pwr_lim_r     <= HLPRC_PWRLIM_RST;
      floor_r       <= HLPRC_FLOOR_RST;
      ceil_r        <= HLPRC_CEIL_RST;
    end else if (wr_en) begin
      if (paddr == HLPRC_CTRL_OFS) begin
        role_bridge_r <= pwdata[0];
        link_ready_r  <= pwdata[1];
      end
      if (paddr == HLPRC_CFG_OFS) begin
        window_r  <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        thr_min_r <= pwdata[15:8];
        level_r   <= pwdata[23:16];
        pwr_lim_r <= pwdata[31:24];
      end
      if (paddr == HLPRC_PWR_OFS) begin
        floor_r <= pwdata[3:0];
        ceil_r  <= pwdata[7:4];
      end
    end
  end

  // Outcome report of one transmission, written by the radio driver
  logic        rpt_we;
  logic [7:0]  rpt_retries;
  logic        rpt_ok;
  logic        rpt_app;
  logic        rpt_mode;
  logic [7:0]  rpt_rssi;

  assign rpt_we      = wr_en && (paddr == HLPRC_REPORT_OFS);
  assign rpt_retries = pwdata[7:0];
  assign rpt_ok      = pwdata[8];
  assign rpt_app     = pwdata[9];
  assign rpt_mode    = pwdata[10];
  assign rpt_rssi    = pwdata[23:16];

  // Rate control state
  logic [7:0]  total_r;
  logic [7:0]  cnt_r;
  logic [7:0]  thresh_r;
  logic        second_r;
  logic        resend_r;
  logic [7:0]  sum;
  logic        win_done;
  logic        sw_evt;

  always_comb begin
    sum      = sat_add(total_r, rpt_retries);
    win_done = rpt_we && !role_bridge_r && rpt_ok && rpt_app && (cnt_r + 8'h01 >= window_r);
    sw_evt   = 1'b0;
    if (rpt_we && !role_bridge_r) begin
      if (!rpt_ok) begin
        sw_evt = !second_r;
      end else if (win_done) begin
        sw_evt = (sum > thresh_r);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_mode_r <= 1'b0;
      total_r     <= 8'h00;
      cnt_r       <= 8'h00;
      thresh_r    <= HLPRC_THRMIN_RST;
      second_r    <= 1'b0;
    end else if (rpt_we && role_bridge_r) begin
      data_mode_r <= rpt_mode;
    end else if (rpt_we) begin
      if (sw_evt) begin
        data_mode_r <= ~data_mode_r;
        thresh_r    <= sum;
        total_r     <= 8'h00;
        cnt_r       <= 8'h00;
        second_r    <= !rpt_ok;
      end else if (!rpt_ok) begin
        second_r <= 1'b0;
        total_r  <= 8'h00;
        cnt_r    <= 8'h00;
      end else begin
        second_r <= 1'b0;
        if (win_done) begin
          if (sum == 8'h00) begin
            thresh_r <= sat_dec(thresh_r, thr_min_r);
          end
          total_r <= 8'h00;
          cnt_r   <= 8'h00;
        end else if (rpt_app) begin
          total_r <= sum;
          cnt_r   <= cnt_r + 8'h01;
        end
      end
    end
  end

  // Resend and reconnect requests; a new event wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resend_r    <= 1'b0;
      reconnect_r <= 1'b0;
    end else begin
      if (rpt_we && !role_bridge_r && !rpt_ok && !second_r) begin
        resend_r <= 1'b1;
      end else if (wr_en && (paddr == HLPRC_TXCMD_OFS)) begin
        resend_r <= 1'b0;
      end
      if (rpt_we && !role_bridge_r && !rpt_ok && second_r) begin
        reconnect_r <= 1'b1;
      end else if (wr_en && (paddr == HLPRC_CTRL_OFS) && pwdata[2]) begin
        reconnect_r <= 1'b0;
      end
    end
  end

  // Transmit power; restore has priority over a step down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_power_r <= HLPRC_CEIL_RST;
    end else if (role_bridge_r) begin
      tx_power_r <= ceil_r;
    end else if (rpt_we) begin
      if (sw_evt || (rpt_ok && rpt_rssi <= level_r) || (rpt_retries > pwr_lim_r)) begin
        tx_power_r <= ceil_r;
      end else if (win_done && sum == 8'h00 && rpt_rssi > level_r) begin
        tx_power_r <= (tx_power_r > floor_r) ? tx_power_r - 4'h1 : floor_r;
      end
    end
  end

  // Transmit header composition
  logic        toggle_r;
  logic [3:0]  cmd_type;
  logic        cmd_new;

  assign cmd_type = pwdata[3:0];
  assign cmd_new  = pwdata[7];

  // Receive side: header decode, payload bytes, identifier compare
  logic [7:0]  rx_hdr_r;
  logic        rx_seen_r;
  logic        rx_repeat_r;
  logic [7:0]  rx_byte_r;
  logic [2:0]  rx_idx_r;
  logic        cmp_pend_r;
  logic        match_r;
  logic        rx_hdr_we;
  logic        rx_byte_we;
  logic [2:0]  byte_idx;
  logic        in_mid;
  logic        mid_we;
  logic [1:0]  mid_waddr;
  logic        join_go;

  assign rx_hdr_we  = wr_en && (paddr == HLPRC_RXHDR_OFS);
  assign rx_byte_we = wr_en && (paddr == HLPRC_RXBYTE_OFS);
  assign byte_idx   = pwdata[10:8];
  assign in_mid     = (byte_idx >= HLPRC_MID_FIRST) && (byte_idx <= HLPRC_MID_LAST);
  assign join_go    = cmp_pend_r && (rx_idx_r == HLPRC_MID_LAST) && role_bridge_r && link_ready_r
                      && (rx_hdr_r[HLPRC_TYPE_MSB:HLPRC_TYPE_LSB] == HLPRC_T_CONNECT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_r    <= 1'b0;
      tx_header_r <= 8'h00;
    end else if (wr_en && (paddr == HLPRC_TXCMD_OFS)) begin
      if (cmd_new && (cmd_type == HLPRC_T_DATA || cmd_type == HLPRC_T_BACK)) begin
        toggle_r    <= ~toggle_r;
        tx_header_r <= build_hdr(cmd_type, pwdata[5:4], pwdata[6], ~toggle_r, pwdata[8]);
      end else begin
        tx_header_r <= build_hdr(cmd_type, pwdata[5:4], pwdata[6], toggle_r, pwdata[8]);
      end
    end else if (rx_hdr_we && role_bridge_r && pwdata[7:4] == HLPRC_T_PAIR) begin
      tx_header_r <= build_hdr(HLPRC_T_PAIR, pwdata[2:1], 1'b0, 1'b0, 1'b0);
    end else if (join_go) begin
      tx_header_r <= build_hdr(HLPRC_T_JOIN, 2'b00, 1'b0, 1'b0, match_r && (mid_cmp == rx_byte_r));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_hdr_r    <= 8'h00;
      rx_seen_r   <= 1'b0;
      rx_repeat_r <= 1'b0;
    end else if (rx_hdr_we) begin
      rx_hdr_r <= pwdata[7:0];
      if (pwdata[7:4] == HLPRC_T_DATA || pwdata[7:4] == HLPRC_T_BACK) begin
        rx_seen_r   <= 1'b1;
        rx_repeat_r <= rx_seen_r && (pwdata[HLPRC_TOGGLE_BIT] == rx_hdr_r[HLPRC_TOGGLE_BIT]);
      end else begin
        rx_repeat_r <= 1'b0;
      end
    end
  end

  // Payload bytes pass through untouched; only identifier bytes are kept or checked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_byte_r  <= 8'h00;
      rx_idx_r   <= 3'h0;
      cmp_pend_r <= 1'b0;
      match_r    <= 1'b0;
    end else begin
      cmp_pend_r <= rx_byte_we && in_mid && role_bridge_r;
      if (rx_byte_we) begin
        rx_byte_r <= pwdata[7:0];
        rx_idx_r  <= byte_idx;
      end
      if (rx_hdr_we) begin
        match_r <= 1'b1;
      end else if (cmp_pend_r && (mid_cmp != rx_byte_r)) begin
        match_r <= 1'b0;
      end
    end
  end

  // HID keeps the identifier carried by the pairing answer
  always_comb begin
    mid_we    = 1'b0;
    mid_waddr = paddr[3:2];
    if (wr_en && is_mid) begin
      mid_we = 1'b1;
    end else if (rx_byte_we && in_mid && !role_bridge_r &&
                 (rx_hdr_r[7:4] == HLPRC_T_PAIR || rx_hdr_r[7:4] == HLPRC_T_AUTOBIND)) begin
      mid_we    = 1'b1;
      mid_waddr = 2'(byte_idx - HLPRC_MID_FIRST);
    end
  end

  hlprc_mid_mem #(
    .DEPTH (4),
    .WIDTH (8)
  ) u_mid (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mid_we),
    .waddr   (mid_waddr),
    .wdata   (pwdata[7:0]),
    .raddr_a (paddr[3:2]),
    .rdata_a (mid_rd),
    .raddr_b (2'(byte_idx - HLPRC_MID_FIRST)),
    .rdata_b (mid_cmp)
  );

  // Back-channel turnaround: seed flip then a fixed quiet delay before listening
  hlprc_bc_t   bc_st_r;
  logic [31:0] bc_cnt_r;
  logic        bc_start;

  assign bc_start = (rpt_we && !role_bridge_r && rpt_ok && tx_header_r[HLPRC_BACK_CHANNEL_REQUEST_BIT_BIT])
                    || (rx_hdr_we && role_bridge_r && pwdata[HLPRC_BACK_CHANNEL_REQUEST_BIT_BIT]
                        && (pwdata[7:4] == HLPRC_T_DATA || pwdata[7:4] == HLPRC_T_NULL));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_seed_r <= HLPRC_SEED_RST;
    end else if (bc_start) begin
      crc_seed_r <= {~crc_seed_r[15:8], crc_seed_r[7:0]};
    end else if (wr_en && (paddr == HLPRC_SEED_OFS)) begin
      crc_seed_r <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bc_st_r     <= HLPRC_BC_IDLE;
      bc_cnt_r    <= 32'h0000_0000;
      bc_listen_r <= 1'b0;
    end else if (bc_start) begin
      bc_st_r     <= HLPRC_BC_WAIT;
      bc_cnt_r    <= 32'(BC_DELAY_CYC - 1);
      bc_listen_r <= 1'b0;
    end else begin
      unique case (bc_st_r)
        HLPRC_BC_IDLE: bc_listen_r <= 1'b0;
        HLPRC_BC_WAIT: begin
          if (bc_cnt_r == 32'h0000_0000) begin
            bc_st_r     <= HLPRC_BC_LISTEN;
            bc_listen_r <= 1'b1;
          end else begin
            bc_cnt_r <= bc_cnt_r - 32'h0000_0001;
          end
        end
        HLPRC_BC_LISTEN: begin
          if (wr_en && (paddr == HLPRC_TXCMD_OFS || paddr == HLPRC_RXHDR_OFS)) begin
            bc_st_r     <= HLPRC_BC_IDLE;
            bc_listen_r <= 1'b0;
          end
        end
        default: bc_st_r <= HLPRC_BC_IDLE;
      endcase
    end
  end

  // Read mux; the identifier word comes from the memory's registered port
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    if (is_mid) begin
      rd_mux = {24'h00_0000, mid_rd};
    end else begin
      unique case (paddr)
        HLPRC_CTRL_OFS:   rd_mux = {29'h0000_0000, reconnect_r, link_ready_r, role_bridge_r};
        HLPRC_CFG_OFS:    rd_mux = {pwr_lim_r, level_r, thr_min_r, window_r};
        HLPRC_PWR_OFS:    rd_mux = {20'h0_0000, tx_power_r, ceil_r, floor_r};
        HLPRC_REPORT_OFS: rd_mux = 32'h0000_0000;
        HLPRC_STATUS_OFS: rd_mux = {cnt_r, total_r, thresh_r, 2'b00, bc_listen_r, match_r,
                                    rx_repeat_r, resend_r, reconnect_r, data_mode_r};
        HLPRC_TXCMD_OFS:  rd_mux = {24'h00_0000, tx_header_r};
        HLPRC_RXHDR_OFS:  rd_mux = {24'h00_0000, rx_hdr_r[HLPRC_BACK_CHANNEL_REQUEST_BIT_BIT], rx_hdr_r[HLPRC_TOGGLE_BIT],
                                    rx_hdr_r[0], rx_hdr_r[1], rx_hdr_r[7:4]};
        HLPRC_RXBYTE_OFS: rd_mux = {21'h00_0000, rx_idx_r, rx_byte_r};
        HLPRC_SEED_OFS:   rd_mux = {16'h0000, crc_seed_r};
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc_first;
      pslverr_r <= acc_first & ~mapped;
      if (acc_first && !pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end
endmodule

// ---- tb/hlprc_top_asserts.sv ----
// Port checks for the packet and rate-control block
`timescale 1ns/1ps
module hlprc_top_asserts
  import hlprc_pkg::*;
#(
  parameter int BC_DELAY_CYC = HLPRC_BC_DELAY_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        data_mode_r,
  input wire logic [3:0]  tx_power_r,
  input wire logic        reconnect_r,
  input wire logic [7:0]  tx_header_r,
  input wire logic        bc_listen_r,
  input wire logic [15:0] crc_seed_r
);
  logic       wr;
  logic       tx;
  logic [3:0] ceil_r;
  logic       role_r;
  assign wr = psel & penable & pready & pwrite;
  assign tx = wr && paddr == HLPRC_TXCMD_OFS;
  // Shadow of the ceiling and role, so power checks follow software changes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ceil_r <= HLPRC_CEIL_RST;
    else if (wr && paddr == HLPRC_PWR_OFS) ceil_r <= pwdata[7:4];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) role_r <= 1'b0;
    else if (wr && paddr == HLPRC_CTRL_OFS) role_r <= pwdata[0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready) else $error("apb wait");
  AST_APB_PULSE: assert property (pready |=> !pready) else $error("pready width");
  AST_SWITCH_PWR: assert property ($changed(data_mode_r) |-> tx_power_r == ceil_r) else $error("switch power");
  AST_MODE_CAUSE: assert property ($changed(data_mode_r) |-> $past(wr && paddr == HLPRC_REPORT_OFS))
    else $error("mode cause");
  AST_PWR_STEP: assert property (tx_power_r < $past(tx_power_r) |-> tx_power_r == $past(tx_power_r) - 4'h1)
    else $error("power step");
  AST_BRIDGE_PWR: assert property (role_r && $past(role_r) |-> tx_power_r == ceil_r) else $error("bridge power");
  AST_RECONNECT: assert property ($rose(reconnect_r) |->
    $past(wr && paddr == HLPRC_REPORT_OFS && !pwdata[8]) && $stable(data_mode_r)) else $error("reconnect");
  AST_DATA_HDR: assert property (tx && pwdata[3:0] == HLPRC_T_DATA && tx_header_r[7:4] == HLPRC_T_DATA |=>
    tx_header_r == {4'h4, $past(pwdata[6]), $past(tx_header_r[2] ^ pwdata[7]), $past(pwdata[4]), $past(pwdata[5])})
    else $error("data header");
  AST_PING_HDR: assert property (tx && pwdata[3:0] == HLPRC_T_PING |=>
    tx_header_r[7:4] == 4'h3 && tx_header_r[0] == $past(pwdata[8])) else $error("ping header");
  AST_PAIR_HDR: assert property (tx && (pwdata[3:0] == HLPRC_T_PAIR || pwdata[3:0] == HLPRC_T_AUTOBIND) |=>
    tx_header_r[2:1] == $past(pwdata[5:4]) && tx_header_r[7:4] == $past(pwdata[3:0])) else $error("pair header");
  AST_SEED_FLIP: assert property ($changed(crc_seed_r) && !$past(wr && paddr == HLPRC_SEED_OFS) |->
    crc_seed_r == {~$past(crc_seed_r[15:8]), $past(crc_seed_r[7:0])}) else $error("seed flip");
  COV_SWITCH: cover property ($changed(data_mode_r));
  COV_RECON: cover property ($rose(reconnect_r));
  COV_LISTEN: cover property ($rose(bc_listen_r));
endmodule
bind hlprc_top hlprc_top_asserts #(.BC_DELAY_CYC(BC_DELAY_CYC)) i_hlprc_top_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .data_mode_r(data_mode_r), .tx_power_r(tx_power_r), .reconnect_r(reconnect_r),
  .tx_header_r(tx_header_r), .bc_listen_r(bc_listen_r), .crc_seed_r(crc_seed_r));

// ---- tb/hlprc_peer.sv ----
// Far-end link model: packs what the air link saw into a report word
`timescale 1ns/1ps
module hlprc_peer (
  input  wire logic [7:0]  retries,
  input  wire logic        jam,
  input  wire logic        app,
  input  wire logic        rx_mode,
  input  wire logic [7:0]  rssi,
  output logic      [31:0] report
);
  // A jammed link never acknowledges, so the retry limit runs out
  assign report = {8'h00, rssi, 5'h00, rx_mode, app, !jam, retries};
endmodule

// ---- tb/hlprc_top_test.sv ----
// Self-checking bench for the packet and rate-control block
`timescale 1ns/1ps
module hlprc_top_test;
  import hlprc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mode, recon, listen, jam, app, rxm, er;
  logic [3:0]  pwr;
  logic [7:0]  paddr, hdr, ret, rssi;
  logic [15:0] seed;
  logic [31:0] pwdata, prdata, rd, rep_w;
  int          n_errors, n_tests, cyc;
  // Rows: command in [27:16], header mask in [15:8], expected header in [7:0]
  logic [31:0] rows [12] = '{32'h00E4FF4D, 32'h0024FF45, 32'h00B4FF43, 32'h0095F352, 32'h0103F131, 32'h0003F130,
                             32'h0030F606, 32'h002DF6D4, 32'h0031F616, 32'h0102F828, 32'h0002F820, 32'h0008F080};
  hlprc_top #(.BC_DELAY_CYC(4)) i_hlprc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_mode_r(mode), .tx_power_r(pwr), .reconnect_r(recon), .tx_header_r(hdr), .bc_listen_r(listen),
    .crc_seed_r(seed));
  hlprc_peer i_hlprc_peer (.retries(ret), .jam(jam), .app(app), .rx_mode(rxm), .rssi(rssi), .report(rep_w));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      give_verdict();
    end
  end
  task give_verdict;
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until pready is seen high at a rising edge; the answer is taken there
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rep(input int n, input logic [7:0] r, input logic j, input logic a, input logic m, input logic [7:0] s);
    ret <= r; jam <= j; app <= a; rxm <= m; rssi <= s;
    @(posedge pclk);
    repeat (n) apb(1'b1, HLPRC_REPORT_OFS, rep_w);
  endtask
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    jam = 1'b0; app = 1'b0; rxm = 1'b0; ret = 8'h00; rssi = 8'h00; n_errors = 0; n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({mode, recon, pwr}, 6'h07);
    foreach (rows[i]) begin
      apb(1'b1, HLPRC_TXCMD_OFS, {20'h0, rows[i][27:16]});
      chk(hdr & rows[i][15:8], rows[i][7:0]);
    end
    for (int i = 0; i < 2; i++) begin
      rep(4, 8'h00, 1'b0, 1'b1, 1'b0, 8'h30);
      chk(pwr, 4'h6);
      rep(1, i ? 8'h04 : 8'h00, 1'b0, 1'b0, 1'b0, i ? 8'h30 : 8'h20);
      chk(pwr, 4'h7);
    end
    rep(4, 8'h00, 1'b0, 1'b1, 1'b0, 8'h30);
    apb(1'b0, HLPRC_STATUS_OFS, 32'h0);
    chk(rd[31:8], 24'h000002);
    rep(4, 8'h01, 1'b0, 1'b1, 1'b0, 8'h30);
    apb(1'b0, HLPRC_STATUS_OFS, 32'h0);
    chk({mode, pwr, rd[31:8]}, 29'h17000004);
    rep(4, 8'h00, 1'b0, 1'b1, 1'b0, 8'h30);
    apb(1'b0, HLPRC_STATUS_OFS, 32'h0);
    chk({pwr, rd[15:8]}, 12'h603);
    rep(1, 8'h05, 1'b1, 1'b1, 1'b0, 8'h30);
    apb(1'b0, HLPRC_STATUS_OFS, 32'h0);
    chk({pwr, rd[15:8], rd[2:0]}, 15'h382C);
    rep(1, 8'h05, 1'b1, 1'b1, 1'b0, 8'h30);
    chk({recon, mode}, 2'b10);
    apb(1'b1, HLPRC_CTRL_OFS, 32'h4);
    chk(recon, 1'b0);
    apb(1'b1, HLPRC_SEED_OFS, 32'h1234);
    apb(1'b1, HLPRC_TXCMD_OFS, 32'h0C4);
    rep(1, 8'h00, 1'b0, 1'b0, 1'b0, 8'h30);
    chk({seed, listen}, 17'h1DA68);
    repeat (3) @(posedge pclk);
    chk(listen, 1'b0);
    @(posedge pclk);
    chk(listen, 1'b1);
    // Step power below the ceiling so the bridge role has something to restore
    rep(4, 8'h00, 1'b0, 1'b1, 1'b0, 8'h30);
    chk(pwr, 4'h6);
    apb(1'b1, HLPRC_CTRL_OFS, 32'h3);
    @(posedge pclk);
    chk(pwr, 4'h7);
    for (int m = 1; m >= 0; m--) begin
      rep(1, 8'h00, 1'b0, 1'b1, m[0], 8'h30);
      chk(mode, m[0]);
    end
    apb(1'b1, HLPRC_RXHDR_OFS, 32'h06);
    chk(hdr & 8'hF6, 8'h06);
    for (int j = 0; j < 4; j++) apb(1'b1, HLPRC_MID_OFS + 8'(4 * j), 32'hA0 + j);
    apb(1'b1, HLPRC_RXHDR_OFS, 32'h16);
    for (int j = 0; j < 4; j++) apb(1'b1, HLPRC_RXBYTE_OFS, {21'h0, 3'(j + 2), 8'(8'hA0 + j)});
    @(posedge pclk);
    chk(hdr & 8'hF8, 8'h28);
    apb(1'b1, HLPRC_RXHDR_OFS, 32'h16);
    apb(1'b1, HLPRC_RXBYTE_OFS, 32'h500);
    @(posedge pclk);
    chk(hdr & 8'hF8, 8'h20);
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd}, 33'h100000000);
    give_verdict();
  end
endmodule
